// File: core/sfp_pkg.sv
// Shared constants for the serial flash command framing and protect block.
// Assumes a 24-bit byte address and an 8 MB array.
package sfp_pkg;
    localparam logic [23:0] ARRAY_TOP = 24'h7fffff;
    localparam logic [23:0] SZ_128K = 24'h020000;
    localparam logic [23:0] SZ_64K = 24'h010000;
    localparam logic [23:0] SZ_32K = 24'h008000;
    localparam logic [23:0] SZ_4K = 24'h001000;
    localparam logic [23:0] SZ_PAGE = 24'h000100;
    localparam int QE_BIT = 9;
    localparam int SYNC_N = 3;
    // Opcodes seen by the framing logic
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_QPP = 8'h32;
    localparam logic [7:0] OP_SE4 = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE_A = 8'hc7;
    localparam logic [7:0] OP_CE_B = 8'h60;
    localparam logic [7:0] OP_SEC_ER = 8'h44;
    localparam logic [7:0] OP_SEC_PR = 8'h42;
    localparam logic [7:0] OP_SUSP = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_PWRDN = 8'hb9;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_QUAD_EN = 8'h38;
    localparam logic [7:0] OP_QUAD_EX = 8'hff;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_ID_AB = 8'hab;
    localparam logic [7:0] OP_ID_90 = 8'h90;
    localparam logic [7:0] OP_ID_92 = 8'h92;
    localparam logic [7:0] OP_ID_94 = 8'h94;
    localparam logic [7:0] OP_ID_9F = 8'h9f;
    typedef enum logic [0:0] {SFP_IDLE, SFP_ACT} sfp_phase_e;
endpackage : sfp_pkg

// File: core/sfp_prot_if.sv
// Carrier between the framing core and the protect-range decoder.
// Assumes both ends sit in the same clock domain; the decoder is combinational.
`timescale 1ns/1ps
interface sfp_prot_if;
    logic cmp;
    logic sec;
    logic tb;
    logic [2:0] bp;
    logic any;
    logic [23:0] lo;
    logic [23:0] hi;
    modport dec (input cmp, input sec, input tb, input bp, output any, output lo, output hi);
    modport user (output cmp, output sec, output tb, output bp, input any, input lo, input hi);
endinterface : sfp_prot_if

// File: core/sfp_prot_dec.sv
// Protected address range decoder: status protect bits in, one range out.
// Assumes the protect bits are stable, registered status from the same clock.
`timescale 1ns/1ps
module sfp_prot_dec
    import sfp_pkg::*;
(
    sfp_prot_if.dec pi
);
    logic [23:0] sz;

    // Size of the plain (non-complemented) protected portion
    always_comb begin
        if (pi.sec) begin
            unique case (pi.bp)
                3'h1: sz = SZ_4K;
                3'h2: sz = SZ_4K << 1;
                3'h3: sz = SZ_4K << 2;
                default: sz = SZ_32K; // 10x; 110 mirrors it
            endcase
        end else begin
            sz = SZ_128K << (pi.bp - 3'h1);
        end
    end

    // Complement only ever yields one range since the plain one hugs an end
    always_comb begin
        pi.lo = 24'h000000;
        pi.hi = ARRAY_TOP;
        if (pi.bp == 3'h0) begin
            pi.any = pi.cmp;
        end else if (pi.bp == 3'h7) begin
            pi.any = ~pi.cmp;
        end else begin
            pi.any = 1'b1;
            if (!pi.cmp) begin
                if (pi.tb) pi.hi = sz - 24'h000001;
                else pi.lo = ARRAY_TOP - sz + 24'h000001;
            end else if (pi.tb) begin
                pi.lo = sz;
            end else begin
                pi.hi = ARRAY_TOP - sz;
            end
        end
    end
endmodule : sfp_prot_dec

// File: core/sfp_core.sv
// Serial flash command framing, byte-boundary, busy and protect gating.
// Assumes link pins arrive asynchronously and are oversampled by clk.
// Functional notes
// - With complement set, field 000 protects all, 111 protects nothing.
// - Complement, sector 0, bottom-anchor 0: codes 1-6 protect lower 63/64 down to 1/2.
// - Complement, sector 0, anchor 1: codes 1-6 protect from 020000h..400000h to top.
// - Complement, sector 1, anchor 0: protect all but top 4K/8K/16K/32K.
// - Complement, sector 1, anchor 1: protect from 001000h..008000h upward; 10x same.
// - Erase or program overlapping any protected address is ignored.
// - Falling chip select starts a command; first byte is the opcode.
// - Single-line mode samples data input on rising clock, MSB first.
// - Quad mode moves each byte on four lines in two clocks, high nibble first.
// - Rising chip select ends a command and commits it.
// - Reads may end after any bit with no side effect.
// - Write, program, erase ending mid-byte are ignored.
// - While busy every command except status read is ignored.
// - Identification bytes returned for ABh/90h/92h/94h, 16-bit code for 9Fh.
// - Quad entry needs quad enable; status write in quad mode keeps it set.
`timescale 1ns/1ps
module sfp_core
    import sfp_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h3c, // Arbitrary value
    parameter logic [15:0] JEDEC_SPI = 16'h1234, // Arbitrary value
    parameter logic [15:0] JEDEC_QUAD = 16'h1235 // Arbitrary value
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n,
    input wire logic complement_protect,
    input wire logic sector_granularity,
    input wire logic top_bottom_select,
    input wire logic [2:0] block_protect_field,
    input wire logic quad_enable,
    input wire logic busy,
    output logic quad_command_mode,
    output logic cmd_valid,
    output logic cmd_rejected,
    output logic [7:0] cmd_opcode,
    output logic [23:0] cmd_addr,
    output logic [15:0] sr_wdata
);
    typedef struct packed {
        logic [SYNC_N-1:0] cs_s;
        logic [SYNC_N-1:0] sck_s;
        logic [4*SYNC_N-1:0] io_s;
        logic cs_f;
        logic sck_f;
        logic [3:0] io_f;
        sfp_phase_e ph;
        logic [2:0] bitpos;
        logic [2:0] bidx;
        logic [7:0] sh;
        logic [7:0] op;
        logic [23:0] addr;
        logic [15:0] srw;
        logic quad;
        logic [3:0] io_out;
        logic [3:0] io_oe_n;
        logic cmd_valid;
        logic cmd_rej;
        logic [7:0] cmd_op;
        logic [23:0] cmd_addr;
        logic [15:0] sr_wdata;
    } sfp_state_s;

    sfp_state_s q;
    sfp_state_s d;
    sfp_prot_if pif ();
    logic cs_new, sck_new, cs_fall, cs_rise, sck_rise, sck_fall;
    logic [3:0] io_new;
    logic [7:0] nb;
    logic [2:0] np;
    logic [8:0] idb;
    logic [47:0] rgn;
    logic prot_hit;
    logic bad;

    sfp_prot_dec u_dec (
        .pi(pif)
    );
    assign pif.cmp = complement_protect;
    assign pif.sec = sector_granularity;
    assign pif.tb = top_bottom_select;
    assign pif.bp = block_protect_field;

    // Commands that act on the device; everything else is treated as a read
    function automatic logic is_cmd(input logic [7:0] op);
        unique case (op)
            OP_WREN, OP_WRDI, OP_VWREN, OP_WRSR, OP_PP, OP_QPP, OP_SE4, OP_BE32,
            OP_BE64, OP_CE_A, OP_CE_B, OP_SEC_ER, OP_SEC_PR, OP_SUSP, OP_RESUME,
            OP_PWRDN, OP_RST_EN, OP_RST, OP_QUAD_EN, OP_QUAD_EX: is_cmd = 1'b1;
            default: is_cmd = 1'b0;
        endcase
    endfunction : is_cmd

    // Array span touched by a program or erase: {first, last}; first above last is empty
    function automatic logic [47:0] region(input logic [7:0] op, input logic [23:0] a);
        logic [23:0] m;
        m = {1'b0, a[22:0]};
        unique case (op)
            OP_PP, OP_QPP: region = {m & ~(SZ_PAGE - 24'h1), m | (SZ_PAGE - 24'h1)};
            OP_SE4: region = {m & ~(SZ_4K - 24'h1), m | (SZ_4K - 24'h1)};
            OP_BE32: region = {m & ~(SZ_32K - 24'h1), m | (SZ_32K - 24'h1)};
            OP_BE64: region = {m & ~(SZ_64K - 24'h1), m | (SZ_64K - 24'h1)};
            OP_CE_A, OP_CE_B: region = {24'h000000, ARRAY_TOP};
            default: region = {ARRAY_TOP, 24'h000000}; // Empty span, never overlaps
        endcase
    endfunction : region

    // Identification byte for the byte slot being shifted out: {valid, byte}
    function automatic logic [8:0] id_byte(input logic [7:0] op, input logic [2:0] bi,
                                           input logic qm);
        logic [15:0] jd;
        jd = qm ? JEDEC_QUAD : JEDEC_SPI;
        id_byte = 9'h000;
        unique case (op)
            OP_ID_9F: begin
                if (bi == 3'h1) id_byte = {1'b1, MAKER_CODE};
                else if (bi == 3'h2) id_byte = {1'b1, jd[15:8]};
                else if (bi == 3'h3) id_byte = {1'b1, jd[7:0]};
            end
            OP_ID_AB: if (bi >= 3'h4) id_byte = {1'b1, PART_CODE};
            OP_ID_90, OP_ID_92, OP_ID_94: begin
                if (bi >= 3'h4) id_byte = {1'b1, bi[0] ? PART_CODE : MAKER_CODE};
            end
            default: id_byte = 9'h000;
        endcase
    endfunction : id_byte

    // Overlap test of the addressed span against the protected range
    always_comb begin
        rgn = region(q.op, q.addr);
        // Empty span must not hit, or a fully protected array would refuse write enable
        prot_hit = pif.any && (rgn[47:24] <= rgn[23:0])
            && (rgn[47:24] <= pif.hi) && (rgn[23:0] >= pif.lo);
    end

    // Next state; filters accept a pin change once stages two and three agree
    always_comb begin
        d = q;
        d.cmd_valid = 1'b0;
        d.cmd_rej = 1'b0;
        d.cs_s = {q.cs_s[SYNC_N-2:0], cs_n_pin};
        d.sck_s = {q.sck_s[SYNC_N-2:0], sck_pin};
        d.io_s = {q.io_s[7:0], io_in};
        cs_new = (q.cs_s[1] == q.cs_s[2]) ? q.cs_s[2] : q.cs_f;
        sck_new = (q.sck_s[1] == q.sck_s[2]) ? q.sck_s[2] : q.sck_f;
        for (int i = 0; i < 4; i++) begin
            io_new[i] = (q.io_s[4+i] == q.io_s[8+i]) ? q.io_s[8+i] : q.io_f[i];
        end
        d.cs_f = cs_new;
        d.sck_f = sck_new;
        d.io_f = io_new;
        cs_fall = q.cs_f & ~cs_new;
        cs_rise = ~q.cs_f & cs_new;
        sck_rise = ~q.sck_f & sck_new;
        sck_fall = q.sck_f & ~sck_new;
        nb = q.quad ? {q.sh[3:0], io_new} : {q.sh[6:0], io_new[0]};
        np = q.bitpos + (q.quad ? 3'h4 : 3'h1);
        idb = id_byte(q.op, q.bidx, q.quad);
        bad = busy || (q.bitpos != 3'h0) || (q.bidx == 3'h0) || prot_hit
            || ((q.op == OP_QUAD_EN) && !quad_enable);
        if (cs_fall) begin
            d.ph = SFP_ACT;
            d.bitpos = 3'h0;
            d.bidx = 3'h0;
            d.op = 8'h00;
            d.io_oe_n = 4'hf;
        end else if (q.ph == SFP_ACT) begin
            if (cs_rise) begin
                d.ph = SFP_IDLE;
                d.io_oe_n = 4'hf;
                // Reads fall through with no effect whatever the bit count
                if (is_cmd(q.op)) begin
                    if (bad) begin
                        d.cmd_rej = 1'b1;
                    end else begin
                        d.cmd_valid = 1'b1;
                        d.cmd_op = q.op;
                        d.cmd_addr = q.addr;
                        d.sr_wdata = q.srw;
                        if (q.quad) d.sr_wdata[QE_BIT] = 1'b1;
                        if (q.op == OP_QUAD_EN) d.quad = 1'b1;
                        if (q.op == OP_QUAD_EX) d.quad = 1'b0;
                    end
                end
            end else if (sck_rise) begin
                d.sh = nb;
                d.bitpos = np;
                if (np == 3'h0) begin
                    unique case (q.bidx)
                        3'h0: d.op = nb;
                        3'h1: begin
                            d.addr[23:16] = nb;
                            d.srw[7:0] = nb;
                        end
                        3'h2: begin
                            d.addr[15:8] = nb;
                            d.srw[15:8] = nb;
                        end
                        3'h3: d.addr[7:0] = nb;
                        default: d.addr = q.addr;
                    endcase
                    if (q.bidx != 3'h7) d.bidx = q.bidx + 3'h1;
                end
            end else if (sck_fall) begin
                // Output changes on the falling edge so it is settled for the host
                if (idb[8] && !busy) begin
                    if (q.quad) begin
                        d.io_out = q.bitpos[2] ? idb[3:0] : idb[7:4];
                        d.io_oe_n = 4'h0;
                    end else begin
                        d.io_out = {2'b00, idb[3'h7 - q.bitpos], 1'b0};
                        d.io_oe_n = 4'hd;
                    end
                end else begin
                    d.io_oe_n = 4'hf;
                end
            end
        end
    end

    // Whole state in one register; ce freezes all of it, synchronisers too
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.cs_s <= '1;
            q.cs_f <= 1'b1;
            q.io_oe_n <= 4'hf;
        end else if (ce) begin
            q <= d;
        end
    end

    assign io_out = q.io_out;
    assign io_oe_n = q.io_oe_n;
    assign quad_command_mode = q.quad;
    assign cmd_valid = q.cmd_valid;
    assign cmd_rejected = q.cmd_rej;
    assign cmd_opcode = q.cmd_op;
    assign cmd_addr = q.cmd_addr;
    assign sr_wdata = q.sr_wdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !ce);

    property p_all_cmp;
        pif.cmp && pif.bp == 3'h0 |-> pif.any && pif.lo == 24'h0 && pif.hi == 24'h7fffff;
    endproperty
    a_all_cmp: assert property (p_all_cmp) else $error("complement 000 not whole array");
    property p_none_cmp;
        pif.cmp && pif.bp == 3'h7 |-> !pif.any;
    endproperty
    a_none_cmp: assert property (p_none_cmp) else $error("complement 111 protects");
    property p_low_6364;
        pif.cmp && !pif.sec && !pif.tb && pif.bp == 3'h1 |-> pif.lo == 24'h0 && pif.hi == 24'h7dffff;
    endproperty
    a_low_6364: assert property (p_low_6364) else $error("lower 63/64 range wrong");
    property p_up_half;
        pif.cmp && !pif.sec && pif.tb && pif.bp == 3'h6 |-> pif.lo == 24'h400000 && pif.hi == 24'h7fffff;
    endproperty
    a_up_half: assert property (p_up_half) else $error("upper half range wrong");
    property p_sec_low;
        pif.cmp && pif.sec && !pif.tb && pif.bp == 3'h1 |-> pif.hi == 24'h7fefff;
    endproperty
    a_sec_low: assert property (p_sec_low) else $error("sector lower range wrong");
    property p_sec_up;
        pif.cmp && pif.sec && pif.tb && pif.bp[2:1] == 2'b10 |-> pif.lo == 24'h008000;
    endproperty
    a_sec_up: assert property (p_sec_up) else $error("sector upper range wrong");
    property p_no_prot_commit;
        cmd_valid |-> !$past(prot_hit) && !$past(busy) && $past(cs_rise);
    endproperty
    a_no_prot_commit: assert property (p_no_prot_commit) else $error("bad commit");
    property p_byte_bound;
        $rose(cmd_valid) |-> $past(q.bitpos) == 3'h0;
    endproperty
    a_byte_bound: assert property (p_byte_bound) else $error("commit mid-byte");
    property p_msb_first;
        q.ph == SFP_ACT && !q.quad && sck_rise && !cs_fall && !cs_rise
            |=> q.sh[0] == $past(io_new[0]) && q.sh[7:1] == $past(q.sh[6:0]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("serial shift wrong");
    property p_quad_entry;
        $rose(quad_command_mode) |-> $past(quad_enable) && $past(q.op) == OP_QUAD_EN;
    endproperty
    a_quad_entry: assert property (p_quad_entry) else $error("quad entry without enable");
endmodule : sfp_core

// File: tb/sfp_host_model.sv
// Host side of the serial link: drives chip select, serial clock and data lines.
// Assumes the bench resolves each data line from this model and the device enables.
`timescale 1ns/1ps
module sfp_host_model (
    output logic cs_n,
    output logic sck,
    output logic [3:0] io_drv,
    input wire logic [3:0] io_line
);
    // Idle link: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        io_drv = 4'h5;
    end

    // One frame of nb whole bytes plus tail loose bit steps; rx gathers what the line shows
    task automatic xfer(input logic [63:0] tx, input int nb, input int tail, input logic quad,
                        output logic [63:0] rx);
        int steps;
        logic [63:0] sh;
        steps = (quad ? nb * 2 : nb * 8) + tail;
        sh = tx;
        rx = '0;
        // Off any clk edge on purpose: the link is asynchronous to the device clock
        #0.7 cs_n = 1'b0;
        #32;
        for (int i = 0; i < steps; i++) begin
            // Unused lines toggle so a stale level never looks like valid data
            io_drv = quad ? sh[63:60] : {~io_drv[3:1], sh[63]};
            sh = quad ? sh << 4 : sh << 1;
            #32 sck = 1'b1;
            rx = quad ? {rx[59:0], io_line} : {rx[62:0], io_line[1]};
            #32 sck = 1'b0;
        end
        #32 cs_n = 1'b1;
        io_drv = ~io_drv;
        #64;
    endtask : xfer
endmodule : sfp_host_model

// File: tb/tb.sv
// Self-checking bench for the serial flash command framing and protect core.
// Assumes the core carries its own assertions and the host model sits beside it.
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] MK = 8'ha7; // Arbitrary value
    localparam logic [7:0] PC = 8'h2d; // Arbitrary value
    localparam logic [15:0] JS = 16'h3e41; // Arbitrary value
    localparam logic [15:0] JQ = 16'h3e42; // Arbitrary value
    // Protect cases: opcode, {sec, tb, bp}, address, outcome (1 taken, 2 refused)
    localparam logic [38:0] PTAB [24] = '{
        {8'h20, 5'b00000, 24'h7ff000, 2'd2}, {8'h20, 5'b00111, 24'h000000, 2'd1},
        {8'h20, 5'b00001, 24'h7df000, 2'd2}, {8'h20, 5'b00001, 24'h7e0000, 2'd1},
        {8'h20, 5'b00110, 24'h3ff000, 2'd2}, {8'h20, 5'b00110, 24'h400000, 2'd1},
        {8'h20, 5'b01001, 24'h01f000, 2'd1}, {8'h20, 5'b01001, 24'h020000, 2'd2},
        {8'h20, 5'b01110, 24'h3ff000, 2'd1}, {8'h20, 5'b01110, 24'h400000, 2'd2},
        {8'h20, 5'b10001, 24'h7fe000, 2'd2}, {8'h20, 5'b10001, 24'h7ff000, 2'd1},
        {8'h20, 5'b10101, 24'h7f7000, 2'd2}, {8'h20, 5'b10101, 24'h7f8000, 2'd1},
        {8'h20, 5'b11001, 24'h000000, 2'd1}, {8'h20, 5'b11001, 24'h001000, 2'd2},
        {8'h20, 5'b11101, 24'h007000, 2'd1}, {8'h20, 5'b11101, 24'h008000, 2'd2},
        {8'hd8, 5'b00001, 24'h7e0000, 2'd1}, {8'h52, 5'b10100, 24'h7f0000, 2'd2},
        {8'h02, 5'b10001, 24'h7fef00, 2'd2}, {8'hc7, 5'b00111, 24'h000000, 2'd1},
        {8'h60, 5'b00001, 24'h000000, 2'd2}, {8'h06, 5'b00000, 24'h000000, 2'd1}};
    localparam logic [7:0] IDOP [4] = '{8'hab, 8'h90, 8'h92, 8'h94};
    logic clk, nrst, cmp, sec, tbs, qe, busy, cs_n, sck, qcm, cv, cr;
    logic [2:0] bp;
    logic [3:0] host_io, io_out, io_oe_n, io_line;
    logic [7:0] op;
    logic [23:0] addr;
    logic [15:0] srw;
    logic [63:0] rx;
    int mismatches = 0;
    int n_checks = 0;
    int nv = 0;
    int nr = 0;

    // A line shows the device while it drives, else what the host leaves there
    assign io_line = (io_oe_n & host_io) | (~io_oe_n & io_out);

    sfp_core #(.MAKER_CODE(MK), .PART_CODE(PC), .JEDEC_SPI(JS), .JEDEC_QUAD(JQ)) dut (
        .clk(clk), .nrst(nrst), .ce(1'b1), .cs_n_pin(cs_n), .sck_pin(sck), .io_in(io_line),
        .io_out(io_out), .io_oe_n(io_oe_n), .complement_protect(cmp),
        .sector_granularity(sec), .top_bottom_select(tbs), .block_protect_field(bp),
        .quad_enable(qe), .busy(busy), .quad_command_mode(qcm), .cmd_valid(cv),
        .cmd_rejected(cr), .cmd_opcode(op), .cmd_addr(addr), .sr_wdata(srw));
    sfp_host_model host (.cs_n(cs_n), .sck(sck), .io_drv(host_io), .io_line(io_line));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Count result pulses so each frame is judged after it ends
    always @(posedge clk) begin
        if (cv === 1'b1) nv <= nv + 1;
        if (cr === 1'b1) nr <= nr + 1;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // One frame, then its outcome: 0 no pulse, 1 taken, 2 refused
    task automatic run(input logic [63:0] tx, input int nb, input int tail, input logic q,
                       input int k);
        int v0, r0;
        v0 = nv;
        r0 = nr;
        host.xfer(tx, nb, tail, q, rx);
        // Pulse lands about four clocks after the pin rise; twelve leaves margin
        repeat (12) @(posedge clk);
        chk("outcome", (nv != v0) ? 32'd1 : (nr != r0) ? 32'd2 : 32'd0, k);
        if (k == 1) chk("opcode", {24'h0, op}, {24'h0, tx[63:56]});
    endtask : run

    // Protect bits change only between frames, so the map is steady for each check
    task automatic prot(input logic [4:0] cfg);
        {sec, tbs, bp} <= cfg;
        cmp <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : prot

    // Hang guard
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    initial begin
        {nrst, cmp, sec, tbs, qe, busy, bp} <= '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        prot(5'b00111);
        run({8'h06, 56'h0}, 1, 0, 1'b0, 1);
        run({8'h06, 56'h0}, 1, 3, 1'b0, 2);
        run({8'h03, 56'h0}, 1, 5, 1'b0, 0);
        busy <= 1'b1;
        run({8'h06, 56'h0}, 1, 0, 1'b0, 2);
        run({8'h05, 56'h0}, 2, 0, 1'b0, 0);
        busy <= 1'b0;
        run({8'h9f, 56'h0}, 4, 0, 1'b0, 0);
        chk("jedec single", {8'h0, rx[23:0]}, {8'h0, MK, JS});
        foreach (IDOP[i]) begin
            run({IDOP[i], 56'h0}, 6, 0, 1'b0, 0);
            chk("id", {16'h0, rx[15:0]}, {16'h0, (IDOP[i] == 8'hab) ? PC : MK, PC});
        end
        foreach (PTAB[i]) begin
            prot(PTAB[i][30:26]);
            run({PTAB[i][38:31], PTAB[i][25:2], 32'h0}, 4, 0, 1'b0, PTAB[i][1:0]);
            if (PTAB[i][1:0] == 2'd1) chk("address", {8'h0, addr}, {8'h0, PTAB[i][25:2]});
        end
        // Plain map once: upper 1/64 protected with complement clear
        {sec, tbs, bp} <= 5'b00001;
        cmp <= 1'b0;
        repeat (2) @(posedge clk);
        run({8'h20, 24'h7e0000, 32'h0}, 4, 0, 1'b0, 2);
        prot(5'b00111);
        run({8'h38, 56'h0}, 1, 0, 1'b0, 2);
        chk("quad mode", {31'h0, qcm}, 32'h0);
        qe <= 1'b1;
        run({8'h38, 56'h0}, 1, 0, 1'b0, 1);
        chk("quad mode", {31'h0, qcm}, 32'h1);
        run({8'h01, 8'ha5, 48'h0}, 3, 0, 1'b1, 1);
        chk("status data", {16'h0, srw}, 32'h02a5);
        run({8'h20, 24'h123000, 32'h0}, 4, 0, 1'b1, 1);
        chk("quad address", {8'h0, addr}, 32'h123000);
        run({8'h9f, 56'h0}, 4, 0, 1'b1, 0);
        chk("jedec quad", {8'h0, rx[23:0]}, {8'h0, MK, JQ});
        run({8'h06, 56'h0}, 1, 1, 1'b1, 2);
        run({8'hff, 56'h0}, 1, 0, 1'b1, 1);
        chk("quad mode", {31'h0, qcm}, 32'h0);
        give_verdict();
    end
endmodule : tb
